// file: rtl/bcu_defs.svh
// register offsets, field positions, reset values and condition codes of the branch unit
`ifndef BCU_DEFS_SVH
`define BCU_DEFS_SVH

`define BCU_ADDR_CTRL        12'h000
`define BCU_ADDR_STATUS      12'h004
`define BCU_ADDR_TAKEN_COUNT 12'h008
`define BCU_ADDR_LAST_TARGET 12'h00C

`define BCU_CTRL_RESET       32'h0000_0001
`define BCU_CTRL_ENABLE_BIT  0
`define BCU_CTRL_VEC_LSB     8
`define BCU_CTRL_VEC_MSB     15

`define BCU_STAT_TAKEN_BIT   0
`define BCU_STAT_FAR_BIT     1
`define BCU_STAT_INT_BIT     2
`define BCU_STAT_COUNT_LSB   16
`define BCU_STAT_COUNT_MSB   31

`define BCU_ZERO32           32'h0000_0000
`define BCU_ONE32            32'h0000_0001
`define BCU_ZERO16           16'h0000
`define BCU_ONE16            16'h0001
`define BCU_STEP_BYTE        16'h0001
`define BCU_STEP_WORD        16'h0002
`define BCU_ZERO8            8'h00

`define BCU_CC_ABOVE         5'h00
`define BCU_CC_ABOVE_EQ      5'h01
`define BCU_CC_BELOW         5'h02
`define BCU_CC_BELOW_EQ      5'h03
`define BCU_CC_CARRY         5'h04
`define BCU_CC_EQUAL         5'h05
`define BCU_CC_GREATER       5'h06
`define BCU_CC_GREATER_EQ    5'h07
`define BCU_CC_LESS          5'h08
`define BCU_CC_LESS_EQ       5'h09
`define BCU_CC_NOT_CARRY     5'h0A
`define BCU_CC_NOT_EQUAL     5'h0B
`define BCU_CC_NOT_OVERFLOW  5'h0C
`define BCU_CC_NOT_PARITY    5'h0D
`define BCU_CC_NOT_SIGN      5'h0E
`define BCU_CC_OVERFLOW      5'h0F
`define BCU_CC_PARITY        5'h10
`define BCU_CC_SIGN          5'h11

`endif

// file: rtl/bcu_pkg.sv
// types shared by the branch condition unit and its bench
package bcu_pkg;

    typedef enum logic [4:0] {
        BCU_OP_NOP                     = 5'h00,
        BCU_OP_COND_JUMP               = 5'h01,
        BCU_OP_COUNT_BRANCH            = 5'h02,
        BCU_OP_COUNT_BRANCH_IF_ZERO    = 5'h03,
        BCU_OP_COUNT_BRANCH_IF_NONZERO = 5'h04,
        BCU_OP_JUMP_IF_COUNT_ZERO      = 5'h05,
        BCU_OP_JUMP_REL                = 5'h06,
        BCU_OP_JUMP_NEAR               = 5'h07,
        BCU_OP_JUMP_FAR                = 5'h08,
        BCU_OP_CALL_REL                = 5'h09,
        BCU_OP_CALL_NEAR               = 5'h0A,
        BCU_OP_CALL_FAR                = 5'h0B,
        BCU_OP_RET_NEAR                = 5'h0C,
        BCU_OP_RET_FAR                 = 5'h0D,
        BCU_OP_SOFT_INT                = 5'h0E,
        BCU_OP_TRAP_OVERFLOW           = 5'h0F,
        BCU_OP_NMI                     = 5'h10,
        BCU_OP_HW_INT                  = 5'h11,
        BCU_OP_INT_RETURN              = 5'h12,
        BCU_OP_STRING                  = 5'h13,
        BCU_OP_FLAG_CONTROL            = 5'h14
    } bcu_op_t;

    typedef enum logic [2:0] {
        BCU_STRING_MOVE    = 3'h0,
        BCU_STRING_COMPARE = 3'h1,
        BCU_STRING_SCAN    = 3'h2,
        BCU_STRING_LOAD    = 3'h3,
        BCU_STRING_STORE   = 3'h4
    } bcu_str_t;

    typedef enum logic [1:0] {
        BCU_ST_IDLE   = 2'b01,
        BCU_ST_ANSWER = 2'b10
    } bcu_fsm_t;

    typedef struct packed {
        logic carryFlag;
        logic parityFlag;
        logic zeroFlag;
        logic signFlag;
        logic overflowFlag;
        logic directionFlag;
    } bcu_flags_t;

    typedef struct packed {
        bcu_op_t     op;
        logic [4:0]  cond;
        logic [7:0]  disp;
        logic [15:0] nextPointer;
        logic [15:0] absPointer;
        logic [15:0] farSegment;
        logic [7:0]  vector;
        logic        wordElem;
        bcu_str_t    strKind;
    } bcu_req_t;

    typedef struct packed {
        logic        taken;
        logic        loadSegment;
        logic        flushQueue;
        logic        intEntry;
        logic        intAckCycle;
        logic        writeCount;
        logic        pushReturn;
        logic        strPrimitive;
        bcu_str_t    strKind;
        logic [15:0] targetPointer;
        logic [15:0] targetSegment;
        logic [15:0] newCount;
        logic [15:0] returnPointer;
        logic [15:0] strStep;
        logic [7:0]  intVector;
        bcu_flags_t  flagsOut;
    } bcu_res_t;

    typedef struct packed {
        bcu_fsm_t    fsm;
        logic        resValid;
        bcu_res_t    res;
        logic [31:0] ctrl;
        logic [31:0] takenCount;
        logic [31:0] prdata;
        logic        pslverr;
    } bcu_state_t;

endpackage

// file: rtl/branch_condition_unit.sv
// branch condition unit: flag tests, short targets, count branches, transfers and interrupt entry
//
// Decided for this implementation: the placing of the registers and the APB register port.
`include "bcu_defs.svh"

module branch_condition_unit (
    input  wire logic                mclk,
    input  wire logic                resetn,
    input  wire logic [11:0]         paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                reqValid,
    output logic                     reqReady,
    input  wire bcu_pkg::bcu_req_t   req,
    input  wire bcu_pkg::bcu_flags_t flags,
    input  wire logic [15:0]         countRegister,
    input  wire logic [15:0]         segmentIn,
    output logic                     resValid,
    output bcu_pkg::bcu_res_t        res
);

    bcu_pkg::bcu_state_t st;
    bcu_pkg::bcu_state_t next_st;
    bcu_pkg::bcu_res_t   r;
    logic                condTrue;
    logic                lessSigned;
    logic [15:0]         relTarget;
    logic [15:0]         decCount;
    logic                take;
    logic                setup;
    logic                access;
    logic                mapped;
    logic [31:0]         rdata;
    logic [31:0]         wmask;
    logic [31:0]         status;

    // condition table for the eighteen conditional branches
    always_comb
    begin
        lessSigned = flags.signFlag ^ flags.overflowFlag;
        case (req.cond)
            `BCU_CC_ABOVE:        condTrue = ~(flags.carryFlag | flags.zeroFlag);
            `BCU_CC_ABOVE_EQ:     condTrue = ~flags.carryFlag;
            `BCU_CC_BELOW:        condTrue = flags.carryFlag;
            `BCU_CC_BELOW_EQ:     condTrue = flags.carryFlag | flags.zeroFlag;
            `BCU_CC_CARRY:        condTrue = flags.carryFlag;
            `BCU_CC_EQUAL:        condTrue = flags.zeroFlag;
            `BCU_CC_GREATER:      condTrue = ~(lessSigned | flags.zeroFlag);
            `BCU_CC_GREATER_EQ:   condTrue = ~lessSigned;
            `BCU_CC_LESS:         condTrue = lessSigned;
            `BCU_CC_LESS_EQ:      condTrue = lessSigned | flags.zeroFlag;
            `BCU_CC_NOT_CARRY:    condTrue = ~flags.carryFlag;
            `BCU_CC_NOT_EQUAL:    condTrue = ~flags.zeroFlag;
            `BCU_CC_NOT_OVERFLOW: condTrue = ~flags.overflowFlag;
            `BCU_CC_NOT_PARITY:   condTrue = ~flags.parityFlag;
            `BCU_CC_NOT_SIGN:     condTrue = ~flags.signFlag;
            `BCU_CC_OVERFLOW:     condTrue = flags.overflowFlag;
            `BCU_CC_PARITY:       condTrue = flags.parityFlag;
            `BCU_CC_SIGN:         condTrue = flags.signFlag;
            // undefined codes never branch, safest for a bad decode
            default:              condTrue = 1'b0;
        endcase
    end

    // short target wraps inside the 64k segment like the pointer itself
    assign relTarget = req.nextPointer + {{8{req.disp[7]}}, req.disp};
    assign decCount  = countRegister - `BCU_ONE16;

    // resolution of one request
    always_comb
    begin
        r               = '0;
        take            = 1'b0;
        r.targetSegment = segmentIn;
        r.targetPointer = req.nextPointer;
        r.returnPointer = req.nextPointer;
        r.newCount      = countRegister;
        r.flagsOut      = flags;
        r.strKind       = req.strKind;
        case (req.op)
            bcu_pkg::BCU_OP_COND_JUMP:
            begin
                take = condTrue;
                if (condTrue)
                begin
                    r.targetPointer = relTarget;
                end
            end
            bcu_pkg::BCU_OP_COUNT_BRANCH,
            bcu_pkg::BCU_OP_COUNT_BRANCH_IF_ZERO,
            bcu_pkg::BCU_OP_COUNT_BRANCH_IF_NONZERO:
            begin
                r.writeCount = 1'b1;
                r.newCount   = decCount;
                take         = decCount != `BCU_ZERO16;
                if (req.op == bcu_pkg::BCU_OP_COUNT_BRANCH_IF_ZERO)
                begin
                    take = take & flags.zeroFlag;
                end
                if (req.op == bcu_pkg::BCU_OP_COUNT_BRANCH_IF_NONZERO)
                begin
                    take = take & ~flags.zeroFlag;
                end
                if (take)
                begin
                    r.targetPointer = relTarget;
                end
            end
            bcu_pkg::BCU_OP_JUMP_IF_COUNT_ZERO:
            begin
                take = countRegister == `BCU_ZERO16;
                if (take)
                begin
                    r.targetPointer = relTarget;
                end
            end
            bcu_pkg::BCU_OP_JUMP_REL,
            bcu_pkg::BCU_OP_CALL_REL:
            begin
                take            = 1'b1;
                r.targetPointer = relTarget;
                r.pushReturn    = req.op == bcu_pkg::BCU_OP_CALL_REL;
            end
            bcu_pkg::BCU_OP_JUMP_NEAR,
            bcu_pkg::BCU_OP_CALL_NEAR,
            bcu_pkg::BCU_OP_RET_NEAR:
            begin
                take            = 1'b1;
                r.targetPointer = req.absPointer;
                r.pushReturn    = req.op == bcu_pkg::BCU_OP_CALL_NEAR;
            end
            bcu_pkg::BCU_OP_JUMP_FAR,
            bcu_pkg::BCU_OP_CALL_FAR,
            bcu_pkg::BCU_OP_RET_FAR,
            bcu_pkg::BCU_OP_INT_RETURN:
            begin
                take            = 1'b1;
                r.loadSegment   = 1'b1;
                r.targetSegment = req.farSegment;
                r.targetPointer = req.absPointer;
                r.pushReturn    = req.op == bcu_pkg::BCU_OP_CALL_FAR;
            end
            bcu_pkg::BCU_OP_SOFT_INT,
            bcu_pkg::BCU_OP_NMI:
            begin
                r.intEntry    = 1'b1;
                r.intAckCycle = 1'b0;
                r.intVector   = req.vector;
                r.pushReturn  = 1'b1;
            end
            bcu_pkg::BCU_OP_TRAP_OVERFLOW:
            begin
                // vector comes from control so software can relocate the trap
                r.intEntry   = flags.overflowFlag;
                r.pushReturn = flags.overflowFlag;
                r.intVector  = st.ctrl[`BCU_CTRL_VEC_MSB:`BCU_CTRL_VEC_LSB];
            end
            bcu_pkg::BCU_OP_HW_INT:
            begin
                // only a maskable external request fetches its vector on the bus
                r.intEntry    = 1'b1;
                r.intAckCycle = 1'b1;
                r.pushReturn  = 1'b1;
            end
            bcu_pkg::BCU_OP_STRING:
            begin
                r.strPrimitive = 1'b1;
                r.strStep      = req.wordElem ? `BCU_STEP_WORD : `BCU_STEP_BYTE;
                if (flags.directionFlag)
                begin
                    r.strStep = `BCU_ZERO16 - r.strStep;
                end
            end
            default:
            begin
                take = 1'b0;
            end
        endcase
        r.taken      = take | r.intEntry;
        r.flushQueue = r.taken;
    end

    // bus decode
    assign setup   = psel & ~penable;
    assign access  = psel & penable;
    assign reqReady = st.fsm == bcu_pkg::BCU_ST_IDLE && st.ctrl[`BCU_CTRL_ENABLE_BIT];
    assign mapped  = paddr == `BCU_ADDR_CTRL || paddr == `BCU_ADDR_STATUS ||
                     paddr == `BCU_ADDR_TAKEN_COUNT || paddr == `BCU_ADDR_LAST_TARGET;
    assign wmask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    always_comb
    begin
        status = `BCU_ZERO32;
        status[`BCU_STAT_TAKEN_BIT] = st.res.taken;
        status[`BCU_STAT_FAR_BIT]   = st.res.loadSegment;
        status[`BCU_STAT_INT_BIT]   = st.res.intEntry;
        status[`BCU_STAT_COUNT_MSB:`BCU_STAT_COUNT_LSB] = st.res.newCount;
        case (paddr)
            `BCU_ADDR_CTRL:        rdata = st.ctrl;
            `BCU_ADDR_STATUS:      rdata = status;
            `BCU_ADDR_TAKEN_COUNT: rdata = st.takenCount;
            `BCU_ADDR_LAST_TARGET: rdata = {st.res.targetSegment, st.res.targetPointer};
            default:               rdata = `BCU_ZERO32;
        endcase
    end

    always_comb
    begin
        next_st          = st;
        next_st.resValid = 1'b0;
        case (st.fsm)
            bcu_pkg::BCU_ST_IDLE:
            begin
                if (reqValid && reqReady)
                begin
                    next_st.res      = r;
                    next_st.resValid = 1'b1;
                    next_st.fsm      = bcu_pkg::BCU_ST_ANSWER;
                end
            end
            bcu_pkg::BCU_ST_ANSWER:
            begin
                next_st.fsm = bcu_pkg::BCU_ST_IDLE;
            end
            default:
            begin
                next_st.fsm = bcu_pkg::BCU_ST_IDLE;
            end
        endcase
        if (setup)
        begin
            next_st.prdata  = pwrite ? `BCU_ZERO32 : rdata;
            next_st.pslverr = ~mapped;
        end
        if (access && pwrite && paddr == `BCU_ADDR_CTRL)
        begin
            next_st.ctrl = (st.ctrl & ~wmask) | (pwdata & wmask);
        end
        // a taken event in the clearing cycle still counts
        if (access && pwrite && paddr == `BCU_ADDR_TAKEN_COUNT)
        begin
            next_st.takenCount = `BCU_ZERO32;
        end
        if (next_st.resValid && r.taken)
        begin
            next_st.takenCount = (access && pwrite && paddr == `BCU_ADDR_TAKEN_COUNT) ?
                                 `BCU_ONE32 : st.takenCount + `BCU_ONE32;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st            <= '0;
            st.fsm        <= bcu_pkg::BCU_ST_IDLE;
            st.ctrl       <= `BCU_CTRL_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // zero-wait slave: data latched in setup, answer in first access cycle
    assign pready   = 1'b1;
    assign prdata   = st.prdata;
    assign pslverr  = st.pslverr & psel & penable;
    assign resValid = st.resValid;
    assign res      = st.res;

endmodule

// file: bench/bcu_monitor.sv
// concurrent checks on the branch condition unit ports
module bcu_monitor (
    input wire logic                mclk,
    input wire logic                resetn,
    input wire logic                reqValid,
    input wire logic                reqReady,
    input wire bcu_pkg::bcu_req_t   req,
    input wire bcu_pkg::bcu_flags_t flags,
    input wire logic [15:0]         countRegister,
    input wire logic                resValid,
    input wire bcu_pkg::bcu_res_t   res
);
    timeunit 1ns;
    timeprecision 1ps;
    logic             take;
    logic [15:0]      rel;
    bcu_pkg::bcu_op_t op;
    assign take = reqValid && reqReady;
    assign op = req.op;
    assign rel = req.nextPointer + {{8{req.disp[7]}}, req.disp};
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    chk_answer_pulse: assert property (take |=> resValid ##1 !resValid)
        else $error("result pulse wrong");
    chk_flush_taken: assert property (resValid |-> res.flushQueue == res.taken)
        else $error("flush differs from taken");
    chk_cond_segment: assert property (take && op == bcu_pkg::BCU_OP_COND_JUMP |=> !res.loadSegment)
        else $error("conditional branch loaded a segment");
    chk_cond_target: assert property (take && op == bcu_pkg::BCU_OP_COND_JUMP |=>
        res.targetPointer == (res.taken ? $past(rel) : $past(req.nextPointer)))
        else $error("conditional target wrong");
    chk_count_step: assert property (take &&
        op inside {[bcu_pkg::BCU_OP_COUNT_BRANCH:bcu_pkg::BCU_OP_COUNT_BRANCH_IF_NONZERO]} |=>
        res.writeCount && res.newCount == $past(countRegister) - 16'h0001 && (res.newCount != 16'h0000 || !res.taken))
        else $error("count branch step wrong");
    chk_count_zero: assert property (take && op == bcu_pkg::BCU_OP_JUMP_IF_COUNT_ZERO |=>
        res.taken == ($past(countRegister) == 16'h0000) && !res.writeCount)
        else $error("count zero jump wrong");
    chk_uncond_taken: assert property (take &&
        op inside {[bcu_pkg::BCU_OP_JUMP_REL:bcu_pkg::BCU_OP_RET_FAR]} |=> res.taken)
        else $error("unconditional transfer not taken");
    chk_far_segment: assert property (take && op inside {bcu_pkg::BCU_OP_JUMP_FAR, bcu_pkg::BCU_OP_CALL_FAR} |=>
        res.loadSegment && res.targetSegment == $past(req.farSegment))
        else $error("far segment not loaded");
    chk_no_ack: assert property (take && op inside {bcu_pkg::BCU_OP_SOFT_INT, bcu_pkg::BCU_OP_NMI} |=>
        res.intEntry && !res.intAckCycle)
        else $error("acknowledge cycle on soft entry");
    chk_trap_overflow: assert property (take && op == bcu_pkg::BCU_OP_TRAP_OVERFLOW |=>
        res.intEntry == $past(flags.overflowFlag))
        else $error("overflow trap wrong");
    chk_flags_kept: assert property (take && op == bcu_pkg::BCU_OP_FLAG_CONTROL |=> res.flagsOut == $past(flags))
        else $error("flags altered");
endmodule

bind branch_condition_unit bcu_monitor chk (
    .mclk(mclk), .resetn(resetn), .reqValid(reqValid), .reqReady(reqReady), .req(req), .flags(flags),
    .countRegister(countRegister), .resValid(resValid), .res(res)
);

// file: bench/bcu_fetch_model.sv
// fetch unit and flag state model: offers one request, stalling for lag cycles first
module bcu_fetch_model (
    input  wire logic                mclk,
    input  wire logic                resetn,
    input  wire logic                start,
    input  wire logic [1:0]          lag,
    input  wire bcu_pkg::bcu_req_t   cmd,
    input  wire bcu_pkg::bcu_flags_t cmdFlags,
    input  wire logic [15:0]         cmdCount,
    input  wire logic                reqReady,
    output bcu_pkg::bcu_req_t        req,
    output bcu_pkg::bcu_flags_t      flags,
    output logic [15:0]              countRegister,
    output logic [15:0]              segmentIn,
    output logic                     reqValid,
    output logic                     busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] waitLeft;
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            reqValid <= 1'b0;
            busy <= 1'b0;
            waitLeft <= 2'h0;
            req <= '0;
            flags <= '0;
            countRegister <= 16'h0000;
            segmentIn <= 16'h0000;
        end
        else if (reqValid && reqReady)
        begin
            // released request, flag and count lines flip so a stale value cannot pass for a held one; segmentIn keeps its value
            reqValid <= 1'b0;
            busy <= 1'b0;
            req <= bcu_pkg::bcu_req_t'(~req);
            flags <= ~flags;
            countRegister <= ~countRegister;
        end
        else if (start && !busy)
        begin
            busy <= 1'b1;
            waitLeft <= lag;
        end
        else if (busy && !reqValid)
        begin
            if (waitLeft == 2'h0)
            begin
                reqValid <= 1'b1;
                req <= cmd;
                flags <= cmdFlags;
                countRegister <= cmdCount;
                segmentIn <= ~cmd.farSegment;
            end
            else
                waitLeft <= waitLeft - 2'h1;
        end
    end
endmodule

// file: bench/branch_condition_unit_tb.sv
// self-checking bench for the branch condition unit
module branch_condition_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        bcu_pkg::bcu_op_t  op;
        bcu_pkg::bcu_res_t res;
    } bcu_note_t;
    logic                mclk = 1'b0;
    logic                resetn, psel, penable, pwrite, pready, pslverr, reqValid, reqReady, resValid, start, busy, err;
    logic [11:0]         paddr;
    logic [31:0]         pwdata, prdata, rd;
    logic [3:0]          pstrb;
    logic [1:0]          lag;
    logic [15:0]         countRegister, segmentIn, cmdCount, c;
    bcu_pkg::bcu_req_t   req, cmd, q;
    bcu_pkg::bcu_flags_t flags, cmdFlags, f;
    bcu_pkg::bcu_res_t   res;
    bcu_note_t           n;
    bcu_note_t           notes[$];
    int                  mismatches, comparisons, cycles, takenTotal, i;
    int                  seed = 92;

    always #2 mclk = ~mclk;

    branch_condition_unit uut (
        .mclk(mclk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reqValid(reqValid), .reqReady(reqReady), .req(req), .flags(flags), .countRegister(countRegister),
        .segmentIn(segmentIn), .resValid(resValid), .res(res)
    );
    bcu_fetch_model fetch (
        .mclk(mclk), .resetn(resetn), .start(start), .lag(lag), .cmd(cmd), .cmdFlags(cmdFlags),
        .cmdCount(cmdCount), .reqReady(reqReady), .req(req), .flags(flags), .countRegister(countRegister),
        .segmentIn(segmentIn), .reqValid(reqValid), .busy(busy)
    );

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic cc(logic [4:0] k, bcu_pkg::bcu_flags_t x);
        logic [17:0] v;
        logic        so;
        so = x.signFlag ^ x.overflowFlag;
        v = {x.signFlag, x.parityFlag, x.overflowFlag, !x.signFlag, !x.parityFlag, !x.overflowFlag, !x.zeroFlag,
             !x.carryFlag, so | x.zeroFlag, so, !so, !(so | x.zeroFlag), x.zeroFlag, x.carryFlag,
             x.carryFlag | x.zeroFlag, x.carryFlag, !x.carryFlag, !(x.carryFlag | x.zeroFlag)};
        return (k < 5'h12) ? v[k] : 1'b0;
    endfunction

    function automatic bcu_pkg::bcu_res_t predict(bcu_pkg::bcu_req_t r, bcu_pkg::bcu_flags_t x, logic [15:0] k);
        bcu_pkg::bcu_res_t e;
        logic [15:0]       dec;
        e = '0;
        e.flagsOut = x;
        dec = k - 16'h0001;
        e.taken = r.op inside {[bcu_pkg::BCU_OP_JUMP_REL:bcu_pkg::BCU_OP_RET_FAR], bcu_pkg::BCU_OP_INT_RETURN};
        e.writeCount = r.op inside {[bcu_pkg::BCU_OP_COUNT_BRANCH:bcu_pkg::BCU_OP_COUNT_BRANCH_IF_NONZERO]};
        e.newCount = e.writeCount ? dec : k;
        case (r.op)
            bcu_pkg::BCU_OP_COND_JUMP: e.taken = cc(r.cond, x);
            bcu_pkg::BCU_OP_COUNT_BRANCH: e.taken = dec != 16'h0000;
            bcu_pkg::BCU_OP_COUNT_BRANCH_IF_ZERO: e.taken = dec != 16'h0000 && x.zeroFlag;
            bcu_pkg::BCU_OP_COUNT_BRANCH_IF_NONZERO: e.taken = dec != 16'h0000 && !x.zeroFlag;
            bcu_pkg::BCU_OP_JUMP_IF_COUNT_ZERO: e.taken = k == 16'h0000;
            bcu_pkg::BCU_OP_TRAP_OVERFLOW: e.intEntry = x.overflowFlag;
            bcu_pkg::BCU_OP_STRING: e.strStep = {14'h0000, r.wordElem, !r.wordElem};
            default: e.intEntry = r.op inside {bcu_pkg::BCU_OP_SOFT_INT, bcu_pkg::BCU_OP_NMI, bcu_pkg::BCU_OP_HW_INT};
        endcase
        if (x.directionFlag)
            e.strStep = 16'h0000 - e.strStep;
        e.targetPointer = r.op inside {[bcu_pkg::BCU_OP_JUMP_NEAR:bcu_pkg::BCU_OP_JUMP_FAR],
            bcu_pkg::BCU_OP_CALL_NEAR, bcu_pkg::BCU_OP_CALL_FAR, bcu_pkg::BCU_OP_RET_NEAR, bcu_pkg::BCU_OP_RET_FAR,
            bcu_pkg::BCU_OP_INT_RETURN} ? r.absPointer : e.taken ? r.nextPointer + {{8{r.disp[7]}}, r.disp} : r.nextPointer;
        e.loadSegment = r.op inside {bcu_pkg::BCU_OP_JUMP_FAR, bcu_pkg::BCU_OP_CALL_FAR, bcu_pkg::BCU_OP_RET_FAR,
            bcu_pkg::BCU_OP_INT_RETURN};
        e.targetSegment = e.loadSegment ? r.farSegment : ~r.farSegment;
        e.intAckCycle = r.op == bcu_pkg::BCU_OP_HW_INT;
        e.intVector = (r.op == bcu_pkg::BCU_OP_TRAP_OVERFLOW) ? 8'h5A : e.intAckCycle ? 8'h00 : r.vector;
        e.taken = e.taken | e.intEntry;
        e.pushReturn = e.intEntry ||
            r.op inside {bcu_pkg::BCU_OP_CALL_REL, bcu_pkg::BCU_OP_CALL_NEAR, bcu_pkg::BCU_OP_CALL_FAR};
        e.flushQueue = e.taken;
        return e;
    endfunction

    task automatic send(logic [1:0] l);
        notes.push_back({q.op, predict(q, f, c)});
        takenTotal += notes[$].res.taken;
        @(posedge mclk);
        cmd <= q;
        cmdFlags <= f;
        cmdCount <= c;
        lag <= l;
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        do
            @(negedge mclk);
        while (busy === 1'b1);
    endtask

    always @(posedge mclk)
        if (resetn && resValid === 1'b1)
        begin
            n = notes.pop_front();
            check("taken", res.taken, n.res.taken);
            check("flush", res.flushQueue, n.res.flushQueue);
            check("segment load", res.loadSegment, n.res.loadSegment);
            check("entry", {res.intEntry, res.intAckCycle}, {n.res.intEntry, n.res.intAckCycle});
            check("push", res.pushReturn, n.res.pushReturn);
            check("flags", res.flagsOut, n.res.flagsOut);
            check("count write", {res.writeCount, res.newCount}, {n.res.writeCount, n.res.newCount});
            if (n.op inside {[bcu_pkg::BCU_OP_COND_JUMP:bcu_pkg::BCU_OP_RET_FAR], bcu_pkg::BCU_OP_INT_RETURN})
                check("target", res.targetPointer, n.res.targetPointer);
            check("segment", res.targetSegment, n.res.targetSegment);
            if (n.res.intEntry)
                check("vector", res.intVector, n.res.intVector);
            if (n.op == bcu_pkg::BCU_OP_STRING)
                check("step", {res.strPrimitive, res.strStep}, {1'b1, n.res.strStep});
        end

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            results();
        end
    end

    initial
    begin
        {resetn, psel, penable, pwrite, start, lag, paddr, pwdata, cmdCount} = '0;
        pstrb = 4'hF;
        cmd = '0;
        cmdFlags = '0;
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0000_0000);
        check("ctrl reset", rd, 32'h0000_0001);
        apb(1'b1, 12'h000, 32'h0000_5A01);
        apb(1'b0, 12'h010, 32'h0000_0000);
        check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
        for (i = 0; i < 420; i++)
        begin
            q = 78'({$random(seed), $random(seed), $random(seed)});
            q.op = bcu_pkg::bcu_op_t'(5'(i % 21));
            q.cond = 5'(i % 20);
            q.strKind = bcu_pkg::bcu_str_t'(3'(i % 5));
            if (i < 189)
                q.disp = ((i / 21) % 3 == 0) ? 8'h00 : ((i / 21) % 3 == 1) ? 8'h7F : 8'h80;
            f = 6'($random(seed));
            c = (i % 4 == 0) ? 16'h0000 : (i % 4 == 1) ? 16'h0001 : 16'($random(seed));
            send(2'(i % 3));
        end
        apb(1'b0, 12'h004, 32'h0000_0000);
        check("status", rd, {n.res.newCount, 13'h0000, n.res.intEntry, n.res.loadSegment, n.res.taken});
        apb(1'b0, 12'h00C, 32'h0000_0000);
        check("last target", rd, {n.res.targetSegment, n.res.targetPointer});
        apb(1'b0, 12'h008, 32'h0000_0000);
        check("taken count", rd, takenTotal);
        apb(1'b1, 12'h008, 32'h0000_0000);
        apb(1'b0, 12'h008, 32'h0000_0000);
        check("count cleared", rd, 32'h0000_0000);
        check("pending", notes.size(), 32'h0000_0000);
        results();
    end
endmodule
